// *** common/piag_pkg.sv ***
// shared constants and carriers for the pointer-indirect address generator
`default_nettype none
package piag_pkg;
	localparam int PTR_W = 23;
	localparam int LOW_W = 16;
	localparam int HIGH_W = 7;
	localparam int WORD_W = 16;
	localparam logic [PTR_W-1:0] PTR_RESET = 23'h000000;
	localparam logic [PTR_W-1:0] STEP_SINGLE = 23'h000001;
	localparam logic [PTR_W-1:0] STEP_DOUBLE = 23'h000002;
	localparam logic [WORD_W-1:0] TEMP_RESET = 16'h0000;

	typedef enum logic [1:0] {
		PIAG_PLAIN,
		PIAG_POST_INC,
		PIAG_POST_DEC,
		PIAG_PRE_INC
	} piag_form_t;

	// decoded operand request
	typedef struct packed {
		logic valid;
		piag_form_t form;
		logic dbl;
		logic circ_en;
	} piag_req_t;

	// address pair to the read port
	typedef struct packed {
		logic valid;
		logic dbl;
		logic [PTR_W-1:0] first;
		logic [PTR_W-1:0] second;
	} piag_addr_t;
endpackage
`default_nettype wire

// *** logic/piag_temp_pair.sv ***
// temporary register pair loaded from single or double reads
`timescale 1ns/1ps
`default_nettype none
module piag_temp_pair #(
	parameter int WORD_W = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// returned read data
	input wire logic rd_valid,
	input wire logic rd_dbl,
	input wire logic [WORD_W-1:0] rd_first,
	input wire logic [WORD_W-1:0] rd_second,
	// register pair
	output logic [WORD_W-1:0] temp_reg_lo,
	output logic [WORD_W-1:0] temp_reg_hi
);
	always_ff @(posedge clk) begin
		if (!rstn) begin
			temp_reg_lo <= piag_pkg::TEMP_RESET;
		end else if (rd_valid) begin
			temp_reg_lo <= rd_first;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			temp_reg_hi <= piag_pkg::TEMP_RESET;
		end else if (rd_valid && rd_dbl) begin
			temp_reg_hi <= rd_second;
		end
	end

	a_pair_order: assert property (@(posedge clk) disable iff (!rstn) rd_valid && rd_dbl |=> temp_reg_lo == $past(rd_first) && temp_reg_hi == $past(rd_second)) else $error("pair order wrong");
	a_single_keep: assert property (@(posedge clk) disable iff (!rstn)
		rd_valid && !rd_dbl |=> temp_reg_lo == $past(rd_first) && $stable(temp_reg_hi))
		else $error("single read disturbed high register");
endmodule
`default_nettype wire

// *** logic/piag_top.sv ***
// pointer-indirect address generator for memory-mapped register accesses
`timescale 1ns/1ps
`default_nettype none
module piag_top #(
	parameter int PTR_W = piag_pkg::PTR_W,
	parameter int WORD_W = piag_pkg::WORD_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// decoded operand request
	input wire piag_pkg::piag_req_t req,
	input wire logic [piag_pkg::LOW_W-1:0] circ_buffer_start,
	// pointer load from the core
	input wire logic ptr_load,
	input wire logic [PTR_W-1:0] ptr_load_val,
	// address to the read port
	output piag_pkg::piag_addr_t rd_addr,
	// read data returned
	input wire logic rd_valid,
	input wire logic [WORD_W-1:0] rd_first,
	input wire logic [WORD_W-1:0] rd_second,
	// pointer and temp pair state
	output logic [PTR_W-1:0] ext_addr_pointer,
	output logic [WORD_W-1:0] temp_reg_lo,
	output logic [WORD_W-1:0] temp_reg_hi
);
	// ------------------------------------------------------------
	// step selection and pointer update
	// ------------------------------------------------------------
	logic [PTR_W-1:0] step;
	logic [PTR_W-1:0] ptr_d;
	logic [PTR_W-1:0] ptr_q;
	logic [PTR_W-1:0] access_ptr;
	logic rd_dbl_q;

	assign step = req.dbl ? piag_pkg::STEP_DOUBLE : piag_pkg::STEP_SINGLE;

	always_comb begin
		ptr_d = ptr_q;
		access_ptr = ptr_q;
		case (req.form)
			piag_pkg::PIAG_PLAIN: begin
				ptr_d = ptr_q;
			end
			piag_pkg::PIAG_POST_INC: begin
				ptr_d = ptr_q + step;
			end
			piag_pkg::PIAG_POST_DEC: begin
				ptr_d = ptr_q - step;
			end
			piag_pkg::PIAG_PRE_INC: begin
				ptr_d = ptr_q + step;
				access_ptr = ptr_d;
			end
			default: begin
				ptr_d = ptr_q;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			ptr_q <= piag_pkg::PTR_RESET;
		end else if (ptr_load) begin
			ptr_q <= ptr_load_val;
		end else if (req.valid) begin
			ptr_q <= ptr_d;
		end
	end

	assign ext_addr_pointer = ptr_q;

	// ------------------------------------------------------------
	// effective address formation
	// ------------------------------------------------------------
	logic [piag_pkg::HIGH_W-1:0] pointer_high_part;
	logic [piag_pkg::LOW_W-1:0] pointer_low_part;
	logic [piag_pkg::LOW_W-1:0] low_sum;
	logic [PTR_W-1:0] first_addr;
	logic [PTR_W-1:0] second_addr;

	assign pointer_high_part = access_ptr[PTR_W-1:piag_pkg::LOW_W];
	assign pointer_low_part = access_ptr[piag_pkg::LOW_W-1:0];
	// low-part sum wraps within 16 bits; no carry into the high part
	assign low_sum = pointer_low_part + (req.circ_en ? circ_buffer_start : 16'h0000);
	assign first_addr = {pointer_high_part, low_sum};
	assign second_addr = first_addr[0] ? first_addr - piag_pkg::STEP_SINGLE
		: first_addr + piag_pkg::STEP_SINGLE;

	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_addr <= '0;
		end else begin
			rd_addr.valid <= req.valid;
			rd_addr.dbl <= req.dbl;
			rd_addr.first <= first_addr;
			rd_addr.second <= req.dbl ? second_addr : first_addr;
		end
	end

	// remembers width of issued access for returned data
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rd_dbl_q <= 1'b0;
		end else if (req.valid) begin
			rd_dbl_q <= req.dbl;
		end
	end

	// ------------------------------------------------------------
	// temporary register pair
	// ------------------------------------------------------------
	piag_temp_pair #(
		.WORD_W(WORD_W)
	) piag_temp_pair_i (
		.clk(clk),
		.rstn(rstn),
		.rd_valid(rd_valid),
		.rd_dbl(rd_dbl_q),
		.rd_first(rd_first),
		.rd_second(rd_second),
		.temp_reg_lo(temp_reg_lo),
		.temp_reg_hi(temp_reg_hi)
	);

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	a_plain_hold: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !ptr_load && req.form == piag_pkg::PIAG_PLAIN |=> $stable(ext_addr_pointer))
		else $error("plain form changed pointer");

	a_post_inc_step: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !ptr_load && req.form == piag_pkg::PIAG_POST_INC
		|=> ext_addr_pointer == $past(ptr_q) + ($past(req.dbl) ? 23'h000002 : 23'h000001))
		else $error("post increment step wrong");

	a_post_dec_step: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !ptr_load && req.form == piag_pkg::PIAG_POST_DEC
		|=> ext_addr_pointer == $past(ptr_q) - ($past(req.dbl) ? 23'h000002 : 23'h000001))
		else $error("post decrement step wrong");

	a_pre_inc_step: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !ptr_load && req.form == piag_pkg::PIAG_PRE_INC
		|=> ext_addr_pointer == $past(ptr_q) + ($past(req.dbl) ? 23'h000002 : 23'h000001))
		else $error("pre increment step wrong");

	a_load_wins: assert property (@(posedge clk) disable iff (!rstn)
		ptr_load |=> ext_addr_pointer == $past(ptr_load_val))
		else $error("pointer load lost");

	a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
		!req.valid && !ptr_load |=> $stable(ext_addr_pointer) && !rd_addr.valid)
		else $error("idle cycle changed pointer or issued access");

	a_dbl_latch: assert property (@(posedge clk) disable iff (!rstn)
		req.valid |=> rd_dbl_q == $past(req.dbl))
		else $error("returned data width not latched");

	// ------------------------------------------------------------
	// address checks
	// ------------------------------------------------------------
	a_plain_addr: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !ptr_load && !req.circ_en && req.form == piag_pkg::PIAG_PLAIN
		|=> rd_addr.first == ext_addr_pointer)
		else $error("plain address not the pointer");

	a_addr_join: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !req.circ_en && req.form != piag_pkg::PIAG_PRE_INC
		|=> rd_addr.first == $past(ptr_q))
		else $error("address not the pointer");

	a_low_sum: assert property (@(posedge clk) disable iff (!rstn)
		req.valid |=> rd_addr.first[piag_pkg::LOW_W-1:0] == $past(access_ptr[piag_pkg::LOW_W-1:0])
		+ ($past(req.circ_en) ? $past(circ_buffer_start) : 16'h0000))
		else $error("low part sum wrong");

	a_post_inc_addr: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !req.circ_en && req.form == piag_pkg::PIAG_POST_INC
		|=> rd_addr.first == $past(ptr_q))
		else $error("post increment address not old pointer");

	a_post_dec_addr: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !req.circ_en && req.form == piag_pkg::PIAG_POST_DEC
		|=> rd_addr.first == $past(ptr_q))
		else $error("post decrement address not old pointer");

	a_pre_inc_addr: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !ptr_load && !req.circ_en && req.form == piag_pkg::PIAG_PRE_INC
		|=> rd_addr.first == ext_addr_pointer)
		else $error("pre increment address not updated pointer");

	a_high_part: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && req.form != piag_pkg::PIAG_PRE_INC
		|=> rd_addr.first[22:16] == $past(ptr_q[22:16]))
		else $error("high part not kept");

	// ------------------------------------------------------------
	// pair and width checks
	// ------------------------------------------------------------
	a_second_addr: assert property (@(posedge clk) disable iff (!rstn)
		rd_addr.valid && rd_addr.dbl
		|-> rd_addr.second == (rd_addr.first[0] ? rd_addr.first - 23'h000001 : rd_addr.first + 23'h000001))
		else $error("second address wrong");

	a_single_pair: assert property (@(posedge clk) disable iff (!rstn)
		req.valid && !req.dbl |=> rd_addr.second == rd_addr.first)
		else $error("single access second address differs");

	a_width_follow: assert property (@(posedge clk) disable iff (!rstn)
		req.valid |=> rd_addr.valid && rd_addr.dbl == $past(req.dbl))
		else $error("access width not followed");
endmodule
`default_nettype wire

// *** verification/piag_rd_port_model.sv ***
// read port model answering each address one cycle later
`timescale 1ns/1ps
`default_nettype none
module piag_rd_port_model (
	// clock
	input wire logic clk,
	// address in, data out
	input wire piag_pkg::piag_addr_t rd_addr,
	output logic rd_valid,
	output logic [15:0] rd_first,
	output logic [15:0] rd_second
);
	initial begin
		rd_valid = 1'b0;
		rd_first = 16'h0000;
		rd_second = 16'h0000;
	end
	// idle data toggles so stale words never look valid
	always @(posedge clk) begin
		rd_valid <= rd_addr.valid;
		rd_first <= rd_addr.valid ? rd_addr.first[15:0] ^ 16'hC3A5 : ~rd_first;
		rd_second <= rd_addr.valid ? rd_addr.second[15:0] ^ 16'hC3A5 : ~rd_second;
	end
endmodule
`default_nettype wire

// *** verification/piag_top_tb.sv ***
// self-checking bench for the pointer-indirect address generator
`timescale 1ns/1ps
`default_nettype none
module piag_top_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	piag_pkg::piag_req_t req = '0;
	logic [15:0] cbs = 16'h0000;
	logic ptr_load = 1'b0;
	logic [22:0] ptr_load_val = 23'h000000;
	piag_pkg::piag_addr_t rd_addr;
	logic rd_valid;
	logic [15:0] rd_first, rd_second, lo, hi;
	logic [22:0] ptr, p, a;
	logic [15:0] exp_hi = 16'h0000;
	int miscompares = 0, n_checks = 0, cycles = 0;

	piag_top piag_top_i (.clk(clk), .rstn(rstn), .req(req), .circ_buffer_start(cbs), .ptr_load(ptr_load),
		.ptr_load_val(ptr_load_val), .rd_addr(rd_addr), .rd_valid(rd_valid), .rd_first(rd_first),
		.rd_second(rd_second), .ext_addr_pointer(ptr), .temp_reg_lo(lo), .temp_reg_hi(hi));
	piag_rd_port_model piag_rd_port_model_i (.clk(clk), .rd_addr(rd_addr), .rd_valid(rd_valid),
		.rd_first(rd_first), .rd_second(rd_second));

	initial begin
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			finish_test();
		end
	end

	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic load(input logic [22:0] v);
		@(negedge clk);
		ptr_load = 1'b1;
		ptr_load_val = v;
		@(negedge clk);
		ptr_load = 1'b0;
		p = v;
	endtask
	task automatic op(input piag_pkg::piag_form_t f, input logic d, input logic c, input logic [15:0] s);
		logic [22:0] st, f1, f2;
		st = d ? piag_pkg::STEP_DOUBLE : piag_pkg::STEP_SINGLE;
		a = (f == piag_pkg::PIAG_PRE_INC) ? p + st : p;
		f1 = {a[22:16], a[15:0] + (c ? s : 16'h0000)};
		f2 = d ? (f1[0] ? f1 - 23'h000001 : f1 + 23'h000001) : f1;
		if (f == piag_pkg::PIAG_POST_INC || f == piag_pkg::PIAG_PRE_INC) p = p + st;
		if (f == piag_pkg::PIAG_POST_DEC) p = p - st;
		@(negedge clk);
		req = '{1'b1, f, d, c};
		cbs = s;
		@(posedge clk);
		#1;
		check(rd_addr.valid, 1);
		check(rd_addr.dbl, d);
		check(rd_addr.first, f1);
		check(rd_addr.second, f2);
		check(ptr, p);
		@(negedge clk);
		req = '0;
		repeat (2) @(posedge clk);
		#1;
		check(lo, f1[15:0] ^ 16'hC3A5);
		if (d) exp_hi = f2[15:0] ^ 16'hC3A5;
		check(hi, exp_hi);
	endtask

	task automatic test_plain();
		load(23'h000012);
		op(piag_pkg::PIAG_PLAIN, 1'b0, 1'b0, 16'h0000);
		op(piag_pkg::PIAG_PLAIN, 1'b1, 1'b1, 16'h0100);
		$display("test_plain done");
	endtask
	task automatic test_post();
		load(23'h000004);
		op(piag_pkg::PIAG_POST_INC, 1'b1, 1'b0, 16'h0000);
		op(piag_pkg::PIAG_POST_INC, 1'b0, 1'b0, 16'h0000);
		load(23'h000005);
		op(piag_pkg::PIAG_POST_DEC, 1'b1, 1'b0, 16'h0000);
		op(piag_pkg::PIAG_POST_DEC, 1'b0, 1'b0, 16'h0000);
		$display("test_post done");
	endtask
	task automatic test_pre_wrap();
		load(23'h00FFFE);
		op(piag_pkg::PIAG_PRE_INC, 1'b1, 1'b0, 16'h0000);
		op(piag_pkg::PIAG_PRE_INC, 1'b0, 1'b0, 16'h0000);
		load(23'h07FFF0);
		op(piag_pkg::PIAG_PLAIN, 1'b1, 1'b1, 16'h0021);
		$display("test_pre_wrap done");
	endtask
	task automatic test_circ();
		load(23'h03FFFF);
		op(piag_pkg::PIAG_POST_INC, 1'b0, 1'b1, 16'h0002);
		op(piag_pkg::PIAG_PRE_INC, 1'b1, 1'b1, 16'h0010);
		op(piag_pkg::PIAG_POST_DEC, 1'b1, 1'b1, 16'hFFFF);
		load(23'h010000);
		op(piag_pkg::PIAG_POST_DEC, 1'b0, 1'b0, 16'h0000);
		$display("test_circ done");
	endtask
	task automatic test_load_wins();
		logic [22:0] old_p;
		old_p = p;
		@(negedge clk);
		req = '{1'b1, piag_pkg::PIAG_POST_INC, 1'b0, 1'b0};
		ptr_load = 1'b1;
		ptr_load_val = 23'h000100;
		@(posedge clk);
		#1;
		check(rd_addr.first, old_p);
		check(ptr, 23'h000100);
		@(negedge clk);
		req = '0;
		ptr_load = 1'b0;
		p = 23'h000100;
		repeat (2) @(posedge clk);
		#1;
		check(lo, old_p[15:0] ^ 16'hC3A5);
		check(hi, exp_hi);
		$display("test_load_wins done");
	endtask
	task automatic test_idle();
		@(negedge clk);
		req = '{1'b0, piag_pkg::PIAG_POST_INC, 1'b1, 1'b0};
		@(posedge clk);
		#1;
		check(rd_addr.valid, 0);
		check(ptr, p);
		$display("test_idle done");
	endtask
	task automatic finish_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		#1;
		check(ptr, 0);
		check(rd_addr, 0);
		check(lo, 0);
		check(hi, 0);
		@(negedge clk);
		rstn = 1'b1;
		test_plain();
		test_post();
		test_pre_wrap();
		test_circ();
		test_load_wins();
		test_idle();
		finish_test();
	end
endmodule
`default_nettype wire
